// file: include/aps_defs.svh
`ifndef APS_DEFS_SVH
`define APS_DEFS_SVH

`define APS_ADDR_W 5
`define APS_DATA_W 8
`define APS_LEVEL_W 7
`define APS_SIGN_BIT 6
`define APS_RSVD_BIT 7
`define APS_SEG_SIX_ADDR 5'h0d
`define APS_SEG_SEVEN_ADDR 5'h0e
`define APS_SEG_EIGHT_ADDR 5'h0f
`define APS_REG_RESET 8'h00
`define APS_NUM_SEGMENTS 4'h8
`define APS_FIRST_OWN_SEG 3'h5
`define APS_MID_SEG 3'h6
`define APS_LAST_SEG 3'h7

`endif

// file: include/aps_pkg.sv
`include "aps_defs.svh"

package aps_pkg;

    typedef logic [`APS_ADDR_W-1:0] aps_addr_t;
    typedef logic [`APS_DATA_W-1:0] aps_data_t;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        aps_addr_t addr;
        aps_data_t wdata;
    } aps_req_s;

    typedef struct packed {
        logic [2:0] seg_sel;
        logic arb_mode;
    } aps_seg_s;

    typedef struct packed {
        aps_data_t seg_six_reg;
        aps_data_t seg_seven_reg;
        aps_data_t seg_eight_reg;
        aps_data_t rdata;
        logic rvalid;
        logic hit;
        logic [`APS_LEVEL_W-1:0] level;
        logic level_valid;
    } aps_state_s;

endpackage

// file: design/aps_segment_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "aps_defs.svh"

module aps_segment_regs (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire aps_pkg::aps_req_s req_i,
    input wire aps_pkg::aps_seg_s seg_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic hit_o,
    output logic [6:0] level_o,
    output logic level_valid_o,
    output logic [7:0] seg_six_o,
    output logic [7:0] seg_seven_o,
    output logic [7:0] seg_eight_o
);
    import aps_pkg::*;

    aps_state_s state_ff;
    aps_state_s nxt_state;
    logic sel_six;
    logic sel_seven;
    logic sel_eight;

    always_comb begin
        sel_six = (req_i.addr == `APS_SEG_SIX_ADDR);
        sel_seven = (req_i.addr == `APS_SEG_SEVEN_ADDR);
        sel_eight = (req_i.addr == `APS_SEG_EIGHT_ADDR);
    end

    always_comb begin
        nxt_state = state_ff;
        // Full byte stored, reserved bit included
        if (req_i.wr_en && sel_six) begin
            nxt_state.seg_six_reg = req_i.wdata;
        end
        if (req_i.wr_en && sel_seven) begin
            nxt_state.seg_seven_reg = req_i.wdata;
        end
        if (req_i.wr_en && sel_eight) begin
            nxt_state.seg_eight_reg = req_i.wdata;
        end
        nxt_state.rvalid = req_i.rd_en;
        nxt_state.hit = req_i.rd_en && (sel_six || sel_seven || sel_eight);
        // Read returns stored value; unmapped addresses read zero
        if (!req_i.rd_en) begin
            nxt_state.rdata = state_ff.rdata;
        end else if (sel_six) begin
            nxt_state.rdata = state_ff.seg_six_reg;
        end else if (sel_seven) begin
            nxt_state.rdata = state_ff.seg_seven_reg;
        end else if (sel_eight) begin
            nxt_state.rdata = state_ff.seg_eight_reg;
        end else begin
            nxt_state.rdata = `APS_REG_RESET;
        end
        // Segment level feed toward the pulse generator, sixth to eighth of eight
        nxt_state.level = '0;
        nxt_state.level_valid = 1'b0;
        if (seg_i.arb_mode) begin
            unique case (seg_i.seg_sel)
                `APS_FIRST_OWN_SEG: begin
                    nxt_state.level = state_ff.seg_six_reg[`APS_LEVEL_W-1:0];
                    nxt_state.level_valid = 1'b1;
                end
                `APS_MID_SEG: begin
                    nxt_state.level = state_ff.seg_seven_reg[`APS_LEVEL_W-1:0];
                    nxt_state.level_valid = 1'b1;
                end
                `APS_LAST_SEG: begin
                    nxt_state.level = state_ff.seg_eight_reg[`APS_LEVEL_W-1:0];
                    nxt_state.level_valid = 1'b1;
                end
                default: begin
                    nxt_state.level = '0;
                    nxt_state.level_valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_comb begin
        rdata_o = state_ff.rdata;
        rvalid_o = state_ff.rvalid;
        hit_o = state_ff.hit;
        level_o = state_ff.level;
        level_valid_o = state_ff.level_valid;
        seg_six_o = state_ff.seg_six_reg;
        seg_seven_o = state_ff.seg_seven_reg;
        seg_eight_o = state_ff.seg_eight_reg;
    end

    property p_write_six;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.wr_en && req_i.addr == `APS_SEG_SIX_ADDR) |=> (seg_six_o == $past(req_i.wdata));
    endproperty
    a_write_six: assert property (p_write_six) else $error("segment six write lost");

    property p_write_seven;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.wr_en && req_i.addr == `APS_SEG_SEVEN_ADDR) |=> (seg_seven_o == $past(req_i.wdata));
    endproperty
    a_write_seven: assert property (p_write_seven) else $error("segment seven write lost");

    property p_write_eight;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.wr_en && req_i.addr == `APS_SEG_EIGHT_ADDR) |=> (seg_eight_o == $past(req_i.wdata));
    endproperty
    a_write_eight: assert property (p_write_eight) else $error("segment eight write lost");

    property p_read_back;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.rd_en && !req_i.wr_en && req_i.addr == `APS_SEG_SEVEN_ADDR)
            |=> (rvalid_o && hit_o && rdata_o == seg_seven_o);
    endproperty
    a_read_back: assert property (p_read_back) else $error("read back mismatch");

    property p_unmapped_zero;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.rd_en && req_i.addr != `APS_SEG_SIX_ADDR && req_i.addr != `APS_SEG_SEVEN_ADDR
            && req_i.addr != `APS_SEG_EIGHT_ADDR) |=> (rdata_o == `APS_REG_RESET && !hit_o);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_mode_gate;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !seg_i.arb_mode |=> (!level_valid_o && level_o == 7'h00);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("level out of arbitrary mode");

    property p_level_eight;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (seg_i.arb_mode && seg_i.seg_sel == `APS_LAST_SEG && !req_i.wr_en)
            |=> (level_valid_o && level_o == seg_eight_o[6:0]);
    endproperty
    a_level_eight: assert property (p_level_eight) else $error("eighth level wrong");

    property p_level_six;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (seg_i.arb_mode && seg_i.seg_sel == `APS_FIRST_OWN_SEG && !req_i.wr_en)
            |=> (level_valid_o && level_o == seg_six_o[6:0] && level_o[6] == seg_six_o[6]);
    endproperty
    a_level_six: assert property (p_level_six) else $error("sixth level wrong");

    // Level feed for the middle slot and for slots owned elsewhere
    property p_level_seven;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (seg_i.arb_mode && seg_i.seg_sel == `APS_MID_SEG && !req_i.wr_en)
            |=> (level_valid_o && level_o == seg_seven_o[6:0]);
    endproperty
    a_level_seven: assert property (p_level_seven) else $error("seventh level wrong");

    property p_level_other;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (seg_i.arb_mode && seg_i.seg_sel < `APS_FIRST_OWN_SEG)
            |=> (!level_valid_o && level_o == 7'h00);
    endproperty
    a_level_other: assert property (p_level_other) else $error("foreign level");

    // Registers keep their value between writes
    property p_hold_six;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !(req_i.wr_en && req_i.addr == `APS_SEG_SIX_ADDR) |=> $stable(seg_six_o);
    endproperty
    a_hold_six: assert property (p_hold_six) else $error("segment six changed");

    property p_hold_seven;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !(req_i.wr_en && req_i.addr == `APS_SEG_SEVEN_ADDR) |=> $stable(seg_seven_o);
    endproperty
    a_hold_seven: assert property (p_hold_seven) else $error("segment seven changed");

    property p_hold_eight;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !(req_i.wr_en && req_i.addr == `APS_SEG_EIGHT_ADDR) |=> $stable(seg_eight_o);
    endproperty
    a_hold_eight: assert property (p_hold_eight) else $error("segment eight changed");

    // Read data for the other two registers
    property p_read_six;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.rd_en && !req_i.wr_en && req_i.addr == `APS_SEG_SIX_ADDR)
            |=> (rvalid_o && hit_o && rdata_o == seg_six_o);
    endproperty
    a_read_six: assert property (p_read_six) else $error("segment six read wrong");

    property p_read_eight;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (req_i.rd_en && !req_i.wr_en && req_i.addr == `APS_SEG_EIGHT_ADDR)
            |=> (rvalid_o && hit_o && rdata_o == seg_eight_o);
    endproperty
    a_read_eight: assert property (p_read_eight) else $error("segment eight read wrong");

    // Every read strobe answers once
    property p_read_strobe;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        req_i.rd_en |=> rvalid_o;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read not answered");

    // Read data holds until the next read
    property p_read_idle;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !req_i.rd_en |=> (!rvalid_o && !hit_o && $stable(rdata_o));
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data moved");

endmodule
`default_nettype wire

// file: tb/aps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module aps_host_model (
    input wire logic sys_clk_i,
    output var aps_pkg::aps_req_s req_o
);
    import aps_pkg::*;
    initial req_o = '0;
    task automatic wr(input aps_addr_t a, input aps_data_t d);
        @(negedge sys_clk_i);
        req_o = '{1'b1, 1'b0, a, d};
        @(negedge sys_clk_i);
        req_o.wr_en = 1'b0;
    endtask
    // Data lines toggle during reads so stale values never look valid
    task automatic rd(input aps_addr_t a);
        @(negedge sys_clk_i);
        req_o = '{1'b0, 1'b1, a, ~req_o.wdata};
        @(negedge sys_clk_i);
        req_o.rd_en = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/arb_pulse_segment_regs_6_to_8_tb.sv
`timescale 1ns/10ps
`default_nettype none
module arb_pulse_segment_regs_6_to_8_tb;
    import aps_pkg::*;
    logic sys_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    aps_req_s req;
    aps_seg_s seg = '0;
    logic [7:0] rdata, s6, s7, s8;
    logic [6:0] level;
    logic rvalid, hit, lvalid;
    int n_mismatch = 0;
    int compares = 0;
    always #2.5 sys_clk_i = ~sys_clk_i;
    aps_host_model u_host (.sys_clk_i(sys_clk_i), .req_o(req));
    aps_segment_regs u_dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .req_i(req),
        .seg_i(seg), .rdata_o(rdata), .rvalid_o(rvalid), .hit_o(hit), .level_o(level),
        .level_valid_o(lvalid), .seg_six_o(s6), .seg_seven_o(s7), .seg_eight_o(s8));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input aps_addr_t a, input aps_data_t e, input logic h);
        u_host.rd(a);
        check({7'h00, rvalid}, 8'h01);
        check({7'h00, hit}, {7'h00, h});
        check(rdata, e);
    endtask
    task automatic test_reset();
        check(s6 | s7 | s8, 8'h00);
        rd_chk(5'h0d, 8'h00, 1'b1);
        rd_chk(5'h0e, 8'h00, 1'b1);
        rd_chk(5'h0f, 8'h00, 1'b1);
        $display("test reset done");
    endtask
    task automatic test_regs();
        u_host.wr(5'h0d, 8'hd5);
        u_host.wr(5'h0e, 8'h85);
        u_host.wr(5'h0f, 8'h7f);
        u_host.wr(5'h0c, 8'hff);
        check(s6, 8'hd5);
        check(s7, 8'h85);
        check(s8, 8'h7f);
        rd_chk(5'h0d, 8'hd5, 1'b1);
        rd_chk(5'h0e, 8'h85, 1'b1);
        rd_chk(5'h0f, 8'h7f, 1'b1);
        rd_chk(5'h0c, 8'h00, 1'b0);
        $display("test regs done");
    endtask
    task automatic test_level();
        logic [6:0] exp;
        for (int i = 0; i < 9; i++) begin
            @(negedge sys_clk_i);
            seg = '{i[2:0], i < 8};
            @(negedge sys_clk_i);
            exp = (i == 5) ? 7'h55 : (i == 6) ? 7'h05 : (i == 7) ? 7'h7f : 7'h00;
            check({1'b0, level}, {1'b0, exp});
            check({7'h00, lvalid}, {7'h00, exp != 7'h00});
        end
        @(negedge sys_clk_i);
        seg = '{3'h7, 1'b0};
        @(negedge sys_clk_i);
        check({7'h00, lvalid}, 8'h00);
        check({1'b0, level}, 8'h00);
        seg = '0;
        $display("test level done");
    endtask
    task automatic test_mid_reset();
        @(negedge sys_clk_i);
        reset_n_i = 1'b0;
        repeat (2) @(negedge sys_clk_i);
        check(s6 | s7 | s8, 8'h00);
        check({lvalid, level}, 8'h00);
        reset_n_i = 1'b1;
        rd_chk(5'h0d, 8'h00, 1'b1);
        rd_chk(5'h0f, 8'h00, 1'b1);
        u_host.wr(5'h0e, 8'h80);
        check(s7, 8'h80);
        rd_chk(5'h0e, 8'h80, 1'b1);
        $display("test mid reset done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk_i);
        reset_n_i = 1'b1;
        test_reset();
        test_regs();
        test_level();
        test_mid_reset();
        give_verdict();
    end
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule
`default_nettype wire
